// ==== rcs_sequencer.v ====
// Clock source sequencer with oscillator waits and flash wait guard
`include "rcs_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module rcs_sequencer #(
    parameter MAIN_WAIT = (`RCS_MAIN_STAB_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS,
    parameter PLL_WAIT = (`RCS_PLL_STAB_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS,
    parameter CW = 17
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Oscillator controls
    input wire main_osc_en_i,
    input wire fast_osc_en_i,
    input wire fast_osc_freq_hi_i,
    input wire [15:0] fast_osc_settle_count_i,
    input wire pll_en_i,
    input wire pll_src_fast_i,
    // System clock and flash wait
    input wire [1:0] clock_source_select_i,
    input wire [1:0] flash_access_wait_i,
    // Module stop requests
    input wire [7:0] module_stop_i,
    // Status
    output reg main_stable_o,
    output reg fast_osc_stable_o,
    output reg pll_stable_o,
    output reg [1:0] sysclk_source_o,
    output reg [7:0] core_clock_mhz_o,
    output reg [1:0] flash_access_wait_o,
    output wire switch_blocked_o,
    output wire wait_illegal_o,
    output reg [7:0] module_run_o
);

    localparam [7:0] RUN_RESET = 8'h03;

    reg [CW-1:0] main_cnt;
    reg [CW-1:0] fast_cnt;
    reg [CW-1:0] pll_cnt;
    reg fast_freq;

    // Fast osc cycles derived from its settle count
    wire [CW-1:0] fast_target = {{(CW-16){1'b0}}, fast_osc_settle_count_i};
    // Settle count of zero behaves as one cycle
    wire [CW-1:0] fast_last = (fast_target == {CW{1'b0}}) ? {CW{1'b0}}
                                                          : fast_target - 1'b1;
    wire [CW-1:0] main_last = MAIN_WAIT[CW-1:0] - 1'b1;
    wire [CW-1:0] pll_last = PLL_WAIT[CW-1:0] - 1'b1;
    wire pll_in_ok = pll_src_fast_i ? fast_osc_stable_o : main_stable_o;

    function [7:0] src_mhz;
        input [1:0] src;
        input hi;
        begin
            case (src)
                `RCS_SRC_FOSC: src_mhz = hi ? `RCS_FOSC_HI_MHZ
                                            : `RCS_FOSC_LO_MHZ;
                `RCS_SRC_MAIN: src_mhz = `RCS_MAIN_MHZ;
                `RCS_SRC_PLL: src_mhz = `RCS_PLL_MHZ;
                default: src_mhz = `RCS_LOCO_MHZ;
            endcase
        end
    endfunction

    function wait_ok;
        input [7:0] mhz;
        input [1:0] w;
        begin
            if (mhz > `RCS_FOSC_HI_MHZ)
                wait_ok = (w == `RCS_WAIT_80);
            else if (mhz >= `RCS_FOSC_LO_MHZ)
                wait_ok = (w == `RCS_WAIT_64) || (w == `RCS_WAIT_80);
            else
                wait_ok = (w != 2'h3);
        end
    endfunction

    reg src_ready;
    always @* begin
        case (clock_source_select_i)
            `RCS_SRC_FOSC: src_ready = fast_osc_stable_o;
            `RCS_SRC_MAIN: src_ready = main_stable_o;
            `RCS_SRC_PLL: src_ready = pll_stable_o;
            default: src_ready = 1'b1;
        endcase
    end

    // Requested source and its frequency
    wire [7:0] req_mhz = src_mhz(clock_source_select_i, fast_freq);
    wire src_change = clock_source_select_i != sysclk_source_o;

    // Flash wait that the next edge will hold
    wire wait_req_ok = wait_ok(core_clock_mhz_o, flash_access_wait_i);
    wire [1:0] next_flash_access_wait = wait_req_ok ? flash_access_wait_i
                                                    : flash_access_wait_o;

    // Held and coming wait must both suit the new clock
    wire req_wait_ok = wait_ok(req_mhz, flash_access_wait_o) &&
                       wait_ok(req_mhz, next_flash_access_wait);
    wire do_switch = src_change && src_ready && req_wait_ok;
    assign switch_blocked_o = src_change && !(src_ready && req_wait_ok);
    assign wait_illegal_o = !wait_req_ok;

    // Main oscillator start/stop and wait
    reg [CW-1:0] next_main_cnt;
    reg next_main_stable;
    always @* begin
        next_main_cnt = main_cnt;
        next_main_stable = main_stable_o;
        if (!main_osc_en_i) begin
            next_main_cnt = {CW{1'b0}};
            next_main_stable = 1'b0;
        end else if (main_cnt >= main_last) begin
            next_main_stable = 1'b1;
        end else begin
            next_main_cnt = main_cnt + 1'b1;
        end
    end

    // Fast oscillator; frequency latched while stopped
    reg [CW-1:0] next_fast_cnt;
    reg next_fast_stable;
    reg next_fast_freq;
    always @* begin
        next_fast_cnt = fast_cnt;
        next_fast_stable = fast_osc_stable_o;
        next_fast_freq = fast_freq;
        if (!fast_osc_en_i) begin
            next_fast_cnt = {CW{1'b0}};
            next_fast_stable = 1'b0;
            next_fast_freq = fast_osc_freq_hi_i;
        end else if (fast_cnt >= fast_last) begin
            next_fast_stable = 1'b1;
        end else begin
            next_fast_cnt = fast_cnt + 1'b1;
        end
    end

    // PLL waits only while its input is stable
    reg [CW-1:0] next_pll_cnt;
    reg next_pll_stable;
    always @* begin
        next_pll_cnt = pll_cnt;
        next_pll_stable = pll_stable_o;
        if (!pll_en_i || !pll_in_ok) begin
            next_pll_cnt = {CW{1'b0}};
            next_pll_stable = 1'b0;
        end else if (pll_cnt >= pll_last) begin
            next_pll_stable = 1'b1;
        end else begin
            next_pll_cnt = pll_cnt + 1'b1;
        end
    end

    // Source switch
    reg [1:0] next_sysclk_source;
    reg [7:0] next_core_clock_mhz;
    always @* begin
        next_sysclk_source = sysclk_source_o;
        next_core_clock_mhz = core_clock_mhz_o;
        if (do_switch) begin
            next_sysclk_source = clock_source_select_i;
            next_core_clock_mhz = req_mhz;
        end
    end

    // Oscillator state
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            main_cnt <= {CW{1'b0}};
            fast_cnt <= {CW{1'b0}};
            pll_cnt <= {CW{1'b0}};
            main_stable_o <= 1'b0;
            fast_osc_stable_o <= 1'b0;
            pll_stable_o <= 1'b0;
            fast_freq <= 1'b0;
        end else begin
            main_cnt <= next_main_cnt;
            main_stable_o <= next_main_stable;
            fast_cnt <= next_fast_cnt;
            fast_osc_stable_o <= next_fast_stable;
            fast_freq <= next_fast_freq;
            pll_cnt <= next_pll_cnt;
            pll_stable_o <= next_pll_stable;
        end
    end

    // Clock source and flash wait
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sysclk_source_o <= `RCS_SRC_LOCO;
            core_clock_mhz_o <= `RCS_LOCO_MHZ;
            flash_access_wait_o <= `RCS_WAIT_NONE;
        end else begin
            sysclk_source_o <= next_sysclk_source;
            core_clock_mhz_o <= next_core_clock_mhz;
            flash_access_wait_o <= next_flash_access_wait;
        end
    end

    // Module run state
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            module_run_o <= RUN_RESET;
        end else begin
            module_run_o <= ~module_stop_i;
        end
    end

endmodule // rcs_sequencer

`default_nettype wire

// ==== rcs_defs.vh ====
// Constants for the reset clock source sequencer
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH

// Clock source select codes
`define RCS_SRC_LOCO 2'h0
`define RCS_SRC_FOSC 2'h1
`define RCS_SRC_MAIN 2'h2
`define RCS_SRC_PLL 2'h3

// Flash access wait settings
`define RCS_WAIT_NONE 2'h0
`define RCS_WAIT_64 2'h1
`define RCS_WAIT_80 2'h2

// Frequencies in MHz
`define RCS_MAIN_MHZ 8'h14
`define RCS_FOSC_LO_MHZ 8'h20
`define RCS_FOSC_HI_MHZ 8'h40
`define RCS_PLL_MHZ 8'h50
`define RCS_LOCO_MHZ 8'h04

// Fast oscillator settle counts
`define RCS_FOSC_WAIT_LO 16'h008E
`define RCS_FOSC_WAIT_HI 16'h010E

// Times in ns, clock period in ns
`define RCS_CLK_NS 100
`define RCS_MAIN_STAB_NS 8192000
`define RCS_PLL_STAB_NS 50000
`define RCS_FOSC_LO_STAB_NS 4438
`define RCS_FOSC_HI_STAB_NS 4219

`endif

// ==== rcs_sequencer_asserts.sv ====
// Checker bound to the clock source sequencer
`timescale 1ns/100ps
`default_nettype none
module rcs_chk (
    // Clock, reset and controls
    input wire logic clk_i, rst_b_i, main_osc_en_i, pll_en_i,
    input wire logic [7:0] module_stop_i,
    // Status
    input wire logic main_stable_o, pll_stable_o, wait_illegal_o,
    input wire logic switch_blocked_o,
    input wire logic [1:0] sysclk_source_o, flash_access_wait_o,
    input wire logic [7:0] core_clock_mhz_o, module_run_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_sw; !$stable(sysclk_source_o); endsequence
    AST_RUN: assert property ($past(rst_b_i) |->
        module_run_o == ~$past(module_stop_i)) else $error("run bad");
    AST_MAIN: assert property (!main_osc_en_i |=> !main_stable_o)
        else $error("main stable bad");
    AST_PLL: assert property (!pll_en_i |=> !pll_stable_o)
        else $error("pll stable bad");
    AST_SW: assert property (s_sw |->
        sysclk_source_o != 2'h3 || $past(pll_stable_o)) else $error("sw bad");
    AST_W32: assert property (core_clock_mhz_o >= 8'h20 |->
        flash_access_wait_o != 2'h0) else $error("wait 32 bad");
    AST_W64: assert property (core_clock_mhz_o > 8'h40 |->
        flash_access_wait_o == 2'h2) else $error("wait 64 bad");
    AST_BLK: assert property (switch_blocked_o |=> $stable(sysclk_source_o))
        else $error("blocked bad");
    AST_ILL: assert property (wait_illegal_o |=> $stable(flash_access_wait_o))
        else $error("illegal bad");
endmodule // rcs_chk
bind rcs_sequencer rcs_chk i_rcs_chk (.*);
`default_nettype wire

// ==== rcs_fw.sv ====
// Boot firmware model that programs the sequencer controls
`timescale 1ns/100ps
`default_nettype none
module rcs_fw (
    // Clock
    input wire logic clk_i,
    // Controls
    output logic main_o, fast_o, hi_o, pll_o, psrc_o,
    output logic [15:0] cnt_o,
    output logic [1:0] src_o, w_o
);
    initial {main_o, fast_o, hi_o, pll_o, psrc_o, src_o, w_o} = 9'h000;
    assign cnt_o = hi_o ? 16'h010E : 16'h008E;
    task set(input logic [4:0] en, input logic [1:0] s, ww);
        @(negedge clk_i);
        {main_o, fast_o, hi_o, pll_o, psrc_o} = en;
        src_o = s;
        w_o = ww;
    endtask
endmodule // rcs_fw
`default_nettype wire

// ==== reset_clock_source_sequencer_tb_top.sv ====
// Testbench for the clock source sequencer
`timescale 1ns/100ps
`default_nettype none
module reset_clock_source_sequencer_tb_top;
    logic clk_i = 0, rst_b_i = 0;
    logic [7:0] module_stop_i = 8'hF0;
    wire main_osc_en_i, fast_osc_en_i, fast_osc_freq_hi_i, pll_en_i;
    wire pll_src_fast_i, main_stable_o, fast_osc_stable_o, pll_stable_o;
    wire switch_blocked_o, wait_illegal_o;
    wire [15:0] fast_osc_settle_count_i;
    wire [1:0] clock_source_select_i, flash_access_wait_i;
    wire [1:0] sysclk_source_o, flash_access_wait_o;
    wire [7:0] core_clock_mhz_o, module_run_o;
    int err_total = 0, compares = 0, n;
    always #50 clk_i = ~clk_i;
    rcs_sequencer #(.MAIN_WAIT(10), .PLL_WAIT(10)) i_rcs_sequencer (.*);
    rcs_fw i_rcs_fw (.clk_i(clk_i), .main_o(main_osc_en_i),
        .fast_o(fast_osc_en_i), .hi_o(fast_osc_freq_hi_i), .pll_o(pll_en_i),
        .psrc_o(pll_src_fast_i), .cnt_o(fast_osc_settle_count_i),
        .src_o(clock_source_select_i), .w_o(flash_access_wait_i));
    task chk(input logic [15:0] s, e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task tk(input int c); repeat (c) @(negedge clk_i); endtask
    task summarize;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task t_main;
        i_rcs_fw.set(5'h10, 2'h2, 2'h0);
        tk(1);
        chk(switch_blocked_o, 1'b1);
        for (n = 1; main_stable_o !== 1'b1 && n < 50; n++) tk(1);
        chk(n[15:0], 16'h000A);
        tk(1);
        chk(sysclk_source_o, 2'h2);
        chk(core_clock_mhz_o, 8'h14);
        $display("main done");
    endtask
    task t_fast;
        i_rcs_fw.set(5'h14, 2'h2, 2'h0);
        i_rcs_fw.set(5'h1C, 2'h1, 2'h0);
        tk(200);
        chk(fast_osc_stable_o, 1'b0);
        tk(100);
        chk(fast_osc_stable_o, 1'b1);
        chk(switch_blocked_o, 1'b1);
        i_rcs_fw.set(5'h1C, 2'h1, 2'h1);
        tk(3);
        chk(core_clock_mhz_o, 8'h40);
        i_rcs_fw.set(5'h1C, 2'h1, 2'h0);
        tk(2);
        chk(wait_illegal_o, 1'b1);
        chk(flash_access_wait_o, 2'h1);
        $display("fast done");
    endtask
    task t_pll;
        i_rcs_fw.set(5'h1F, 2'h3, 2'h1);
        tk(20);
        chk(pll_stable_o, 1'b1);
        chk(switch_blocked_o, 1'b1);
        i_rcs_fw.set(5'h1F, 2'h3, 2'h2);
        tk(3);
        chk(core_clock_mhz_o, 8'h50);
        i_rcs_fw.set(5'h17, 2'h3, 2'h2);
        tk(2);
        chk(pll_stable_o, 1'b0);
        $display("pll done");
    endtask
    initial begin
        tk(10);
        chk(module_run_o, 8'h03);
        rst_b_i = 1;
        tk(2);
        chk(module_run_o, 8'h0F);
        $display("reset done");
        t_main;
        t_fast;
        t_pll;
        summarize;
    end
    initial begin
        #200000;
        err_total++;
        summarize;
    end
endmodule // reset_clock_source_sequencer_tb_top
`default_nettype wire
